// [include/ptcm_pkg.sv]
// Purpose: constants for the telemetry and configuration command slice
// Assumes: byte-wide command codes, two channels selected by a page bit
// Notes: Behaviour list below is the contract of this slice
//
// Behaviour
// - External diode temperature, a paged word, feeds gain compensation.
// - Die temperature is unpaged and affects nothing else.
// - Paged word reports high-side gate duty cycle in percent.
// - One read-only byte gives supported protocol revision.
// - Serial number is an unpaged read-only block, no fixed default.
// - Paged output voltage ceiling, different for channel 0 and 1.
// - User words are read/write, reset zero; one paged, one shared.
// - Erase and stream access refused until unlock byte written.
// - Erase command prepares the user store for bulk programming.
// - Stream word moves one word per transfer, address advancing.
// - Paged channel config byte resets to 0x1f.
// - Shared global config byte resets to 0x09.
// - Paged fault pin propagation word resets to 0x2993, drives pins.
// - Paged modulator settings byte resets to 0xc2.
// - Fault pin pulled low triggers paged action byte, reset 0xc0.
// - Fixed read-only die overheat action byte 0xc0 applied.
// - Per-channel peak output current kept until peaks cleared.
// - Paged extra bus address, reset 0x80, targets its channel.
// - Nonvolatile commands saved on store-all, reloaded on restore-all.
// - Write to unpublished read-only command raises fault status bit 6.

package ptcm_pkg;
  localparam logic [7:0] CMD_VOUT = 8'h8b;
  localparam logic [7:0] CMD_IOUT = 8'h8c;
  localparam logic [7:0] CMD_TEMP_EXT = 8'h8d;
  localparam logic [7:0] CMD_TEMP_DIE = 8'h8e;
  localparam logic [7:0] CMD_DUTY = 8'h94;
  localparam logic [7:0] CMD_POUT = 8'h96;
  localparam logic [7:0] CMD_REV = 8'h98;
  localparam logic [7:0] CMD_MAKER = 8'h99;
  localparam logic [7:0] CMD_PART = 8'h9a;
  localparam logic [7:0] CMD_SERIAL = 8'h9e;
  localparam logic [7:0] CMD_VCEIL = 8'ha5;
  localparam logic [7:0] CMD_OEM0 = 8'hb0;
  localparam logic [7:0] CMD_TOOL = 8'hb1;
  localparam logic [7:0] CMD_OEM2 = 8'hb2;
  localparam logic [7:0] CMD_UPAGED = 8'hb3;
  localparam logic [7:0] CMD_USHARED = 8'hb4;
  localparam logic [7:0] CMD_INFO = 8'hb6;
  localparam logic [7:0] CMD_UNLOCK = 8'hbd;
  localparam logic [7:0] CMD_ERASE = 8'hbe;
  localparam logic [7:0] CMD_STREAM = 8'hbf;
  localparam logic [7:0] CMD_CHCFG = 8'hd0;
  localparam logic [7:0] CMD_GLCFG = 8'hd1;
  localparam logic [7:0] CMD_PROP = 8'hd2;
  localparam logic [7:0] CMD_MOD = 8'hd4;
  localparam logic [7:0] CMD_PINACT = 8'hd5;
  localparam logic [7:0] CMD_OTACT = 8'hd6;
  localparam logic [7:0] CMD_PEAK = 8'hd7;
  localparam logic [7:0] CMD_CHADDR = 8'hd8;

  localparam logic [15:0] RST_USER = 16'h0000;
  localparam logic [7:0] RST_CHCFG = 8'h1f;
  localparam logic [7:0] RST_GLCFG = 8'h09;
  localparam logic [15:0] RST_PROP = 16'h2993;
  localparam logic [7:0] RST_MOD = 8'hc2;
  localparam logic [7:0] RST_PINACT = 8'hc0;
  localparam logic [7:0] OT_ACTION = 8'hc0;
  localparam logic [7:0] RST_CHADDR = 8'h80;

  // Ceilings in 16-bit linear form with exponent -12
  localparam logic [15:0] VCEIL_CH0 = 16'h4189;
  localparam logic [15:0] VCEIL_CH1 = 16'h5800;

  // Arbitrary neutral identity values
  localparam logic [7:0] PROTO_REV = 8'h22;
  localparam logic [7:0] MAKER_CODE = 8'h5a;
  localparam logic [7:0] PART_CODE = 8'h5b;
  localparam logic [15:0] INFO_WORD = 16'h0000;
  localparam logic [7:0] UNLOCK_KEY = 8'h2b;
  localparam logic [7:0] ERASE_KEY = 8'h2c;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  localparam int NVM_AW = 6;
  localparam int NVM_DEPTH = 64;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LOCKED = 1;
  localparam int FAULT_BIT = 6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_STORE = 2'b10,
    ST_LOAD = 2'b11
  } ptcm_state_t;
endpackage

// [hw/ptcm_peak.sv]
// Purpose: running maximum of one channel's current reading
// Assumes: readings are unsigned magnitudes
// Notes: clear wins over a new sample in the same cycle
`timescale 1ns/100ps
module ptcm_peak (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  output logic [15:0] peak_r
);
  always_ff @(posedge sys_clk) begin
    if (sys_rst || clear) begin
      peak_r <= 16'h0000;
    end else if (sample_valid && sample > peak_r) begin
      peak_r <= sample;
    end
  end
endmodule

// [hw/ptcm_map.sv]
// Purpose: command map for telemetry, identity, user store and config
// Assumes: a protocol engine delivers decoded command reads and writes
// Notes: two channels; page selects which copy paged commands touch
`timescale 1ns/100ps
module ptcm_map (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic page,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic wr_unpublished_ro,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_refused,
  output logic comm_fault_r,
  input wire logic comm_fault_clear,
  input wire logic [15:0] vout_ch0,
  input wire logic [15:0] vout_ch1,
  input wire logic [15:0] iout_ch0,
  input wire logic [15:0] iout_ch1,
  input wire logic iout_valid,
  input wire logic [15:0] temp_ext_ch0,
  input wire logic [15:0] temp_ext_ch1,
  input wire logic [15:0] temp_die,
  input wire logic [15:0] duty_ch0,
  input wire logic [15:0] duty_ch1,
  input wire logic [15:0] pout_ch0,
  input wire logic [15:0] pout_ch1,
  input wire logic [7:0] serial_byte,
  input wire logic peak_clear_request,
  input wire logic store_all,
  input wire logic restore_all,
  output logic nvm_busy,
  output logic [15:0] sense_temp_ch0,
  output logic [15:0] sense_temp_ch1,
  input wire logic [1:0] fault_pin_in,
  input wire logic [15:0] fault_src_ch0,
  input wire logic [15:0] fault_src_ch1,
  output logic [1:0] fault_pin_out,
  output logic [1:0] fault_pin_oe_n,
  output logic [7:0] pin_action_ch0,
  output logic [7:0] pin_action_ch1,
  output logic [1:0] pin_action_trig,
  output logic [7:0] ot_action,
  output logic [7:0] chcfg_ch0,
  output logic [7:0] chcfg_ch1,
  output logic [7:0] glcfg,
  output logic [7:0] mod_ch0,
  output logic [7:0] mod_ch1,
  output logic [6:0] chaddr_ch0,
  output logic [6:0] chaddr_ch1,
  output logic [1:0] chaddr_en
);

  // ----------------------------------------
  // Writable command storage
  // ----------------------------------------
  logic [15:0] upaged_r [2];
  logic [15:0] ushared_r;
  logic [15:0] oem0_r;
  logic [15:0] oem2_r;
  logic [15:0] tool_r [2];
  logic [7:0] chcfg_r [2];
  logic [7:0] glcfg_r;
  logic [15:0] prop_r [2];
  logic [7:0] mod_r [2];
  logic [7:0] pinact_r [2];
  logic [7:0] chaddr_r [2];
  logic unlocked_r;
  ptcm_pkg::ptcm_state_t state_r;
  logic [ptcm_pkg::NVM_AW-1:0] ptr_r;
  logic [15:0] nvm_r [ptcm_pkg::NVM_DEPTH];

  // Saved image of every nonvolatile command
  localparam int IMG_N = 16;
  logic [15:0] img_r [IMG_N];
  logic [15:0] live [IMG_N];
  logic [3:0] img_idx_r;

  logic pi;
  logic wr;
  logic idle;
  logic nvm_cmd;
  assign pi = page;
  assign idle = (state_r == ptcm_pkg::ST_IDLE);
  assign nvm_cmd = (cmd_code == ptcm_pkg::CMD_ERASE) ||
                   (cmd_code == ptcm_pkg::CMD_STREAM);
  assign wr = cmd_wr && idle;

  // Stream refused before unlock or while a long job runs
  assign cmd_refused = (cmd_wr || cmd_rd) &&
                       ((nvm_cmd && !unlocked_r) || !idle);
  assign cmd_ack = (cmd_wr || cmd_rd) && !cmd_refused;
  assign nvm_busy = !idle;

  // ----------------------------------------
  // Host writes to read/write commands
  // ----------------------------------------
  // Read-only codes have no case here, so writes leave them intact
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < 2; c++) begin
        upaged_r[c] <= ptcm_pkg::RST_USER;
        tool_r[c] <= ptcm_pkg::RST_USER;
        chcfg_r[c] <= ptcm_pkg::RST_CHCFG;
        prop_r[c] <= ptcm_pkg::RST_PROP;
        mod_r[c] <= ptcm_pkg::RST_MOD;
        pinact_r[c] <= ptcm_pkg::RST_PINACT;
        chaddr_r[c] <= ptcm_pkg::RST_CHADDR;
      end
      ushared_r <= ptcm_pkg::RST_USER;
      oem0_r <= ptcm_pkg::RST_USER;
      oem2_r <= ptcm_pkg::RST_USER;
      glcfg_r <= ptcm_pkg::RST_GLCFG;
    end else if (state_r == ptcm_pkg::ST_LOAD) begin
      case (img_idx_r)
        4'h0: upaged_r[0] <= img_r[0];
        4'h1: upaged_r[1] <= img_r[1];
        4'h2: ushared_r <= img_r[2];
        4'h3: oem0_r <= img_r[3];
        4'h4: oem2_r <= img_r[4];
        4'h5: tool_r[0] <= img_r[5];
        4'h6: tool_r[1] <= img_r[6];
        4'h7: {chcfg_r[1], chcfg_r[0]} <= img_r[7];
        4'h8: {mod_r[1], mod_r[0]} <= img_r[8];
        4'h9: prop_r[0] <= img_r[9];
        4'ha: prop_r[1] <= img_r[10];
        4'hb: {pinact_r[1], pinact_r[0]} <= img_r[11];
        4'hc: {chaddr_r[1], chaddr_r[0]} <= img_r[12];
        4'hd: glcfg_r <= img_r[13][7:0];
        default: ;
      endcase
    end else if (wr) begin
      case (cmd_code)
        ptcm_pkg::CMD_UPAGED: upaged_r[pi] <= cmd_wdata;
        ptcm_pkg::CMD_USHARED: ushared_r <= cmd_wdata;
        ptcm_pkg::CMD_OEM0: oem0_r <= cmd_wdata;
        ptcm_pkg::CMD_OEM2: oem2_r <= cmd_wdata;
        ptcm_pkg::CMD_TOOL: tool_r[pi] <= cmd_wdata;
        ptcm_pkg::CMD_CHCFG: chcfg_r[pi] <= cmd_wdata[7:0];
        ptcm_pkg::CMD_GLCFG: glcfg_r <= cmd_wdata[7:0];
        ptcm_pkg::CMD_PROP: prop_r[pi] <= cmd_wdata;
        ptcm_pkg::CMD_MOD: mod_r[pi] <= cmd_wdata[7:0];
        ptcm_pkg::CMD_PINACT: pinact_r[pi] <= cmd_wdata[7:0];
        ptcm_pkg::CMD_CHADDR: chaddr_r[pi] <= cmd_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Store image and user store sequencing
  // ----------------------------------------
  always_comb begin
    live[0] = upaged_r[0];
    live[1] = upaged_r[1];
    live[2] = ushared_r;
    live[3] = oem0_r;
    live[4] = oem2_r;
    live[5] = tool_r[0];
    live[6] = tool_r[1];
    live[7] = {chcfg_r[1], chcfg_r[0]};
    live[8] = {mod_r[1], mod_r[0]};
    live[9] = prop_r[0];
    live[10] = prop_r[1];
    live[11] = {pinact_r[1], pinact_r[0]};
    live[12] = {chaddr_r[1], chaddr_r[0]};
    live[13] = {8'h00, glcfg_r};
    live[14] = 16'h0000;
    live[15] = 16'h0000;
  end

  // Image starts at power-on values so restore before store is safe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < IMG_N; i++) begin
        img_r[i] <= 16'h0000;
      end
      img_r[7] <= {ptcm_pkg::RST_CHCFG, ptcm_pkg::RST_CHCFG};
      img_r[8] <= {ptcm_pkg::RST_MOD, ptcm_pkg::RST_MOD};
      img_r[9] <= ptcm_pkg::RST_PROP;
      img_r[10] <= ptcm_pkg::RST_PROP;
      img_r[11] <= {ptcm_pkg::RST_PINACT, ptcm_pkg::RST_PINACT};
      img_r[12] <= {ptcm_pkg::RST_CHADDR, ptcm_pkg::RST_CHADDR};
      img_r[13] <= {8'h00, ptcm_pkg::RST_GLCFG};
    end else if (state_r == ptcm_pkg::ST_STORE) begin
      img_r[img_idx_r] <= live[img_idx_r];
    end
  end

  // One word per cycle; long jobs refuse other traffic
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ptcm_pkg::ST_IDLE;
      img_idx_r <= 4'h0;
    end else begin
      case (state_r)
        ptcm_pkg::ST_IDLE: begin
          img_idx_r <= 4'h0;
          if (store_all) begin
            state_r <= ptcm_pkg::ST_STORE;
          end else if (restore_all) begin
            state_r <= ptcm_pkg::ST_LOAD;
          end else if (wr && unlocked_r &&
                       cmd_code == ptcm_pkg::CMD_ERASE &&
                       cmd_wdata[7:0] == ptcm_pkg::ERASE_KEY) begin
            state_r <= ptcm_pkg::ST_ERASE;
          end
        end
        ptcm_pkg::ST_ERASE: begin
          img_idx_r <= 4'h0;
          if (ptr_r == ptcm_pkg::NVM_AW'(ptcm_pkg::NVM_DEPTH - 1)) begin
            state_r <= ptcm_pkg::ST_IDLE;
          end
        end
        ptcm_pkg::ST_STORE, ptcm_pkg::ST_LOAD: begin
          img_idx_r <= img_idx_r + 4'h1;
          if (img_idx_r == 4'hf) begin
            state_r <= ptcm_pkg::ST_IDLE;
          end
        end
        default: state_r <= ptcm_pkg::ST_IDLE;
      endcase
    end
  end

  // Unlock is dropped only by reset or a wrong key
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      unlocked_r <= 1'b0;
    end else if (wr && cmd_code == ptcm_pkg::CMD_UNLOCK) begin
      unlocked_r <= (cmd_wdata[7:0] == ptcm_pkg::UNLOCK_KEY);
    end
  end

  // Stream pointer advances per word transfer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ptr_r <= '0;
    end else if (state_r == ptcm_pkg::ST_ERASE) begin
      nvm_r[ptr_r] <= ptcm_pkg::ERASED_WORD;
      ptr_r <= ptr_r + 1'b1;
    end else if (cmd_ack && cmd_code == ptcm_pkg::CMD_STREAM) begin
      if (cmd_wr) begin
        nvm_r[ptr_r] <= cmd_wdata;
      end
      ptr_r <= ptr_r + 1'b1;
    end else if ((cmd_ack && cmd_code == ptcm_pkg::CMD_UNLOCK) ||
                 (cmd_wr && cmd_code == ptcm_pkg::CMD_ERASE)) begin
      ptr_r <= '0; // Erase must sweep from the first word
    end
  end

  // ----------------------------------------
  // Communication fault flag
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      comm_fault_r <= 1'b0;
    end else if (wr_unpublished_ro) begin
      comm_fault_r <= 1'b1;
    end else if (comm_fault_clear) begin
      comm_fault_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Peak current trackers
  // ----------------------------------------
  logic [15:0] peak0;
  logic [15:0] peak1;
  ptcm_peak u_peak0 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clear(peak_clear_request),
    .sample_valid(iout_valid),
    .sample(iout_ch0),
    .peak_r(peak0)
  );
  ptcm_peak u_peak1 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clear(peak_clear_request),
    .sample_valid(iout_valid),
    .sample(iout_ch1),
    .peak_r(peak1)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] rd_nxt;
  always_comb begin
    rd_nxt = 16'h0000;
    case (cmd_code)
      ptcm_pkg::CMD_VOUT: rd_nxt = pi ? vout_ch1 : vout_ch0;
      ptcm_pkg::CMD_IOUT: rd_nxt = pi ? iout_ch1 : iout_ch0;
      ptcm_pkg::CMD_TEMP_EXT:
        rd_nxt = pi ? temp_ext_ch1 : temp_ext_ch0;
      ptcm_pkg::CMD_TEMP_DIE: rd_nxt = temp_die;
      ptcm_pkg::CMD_DUTY: rd_nxt = pi ? duty_ch1 : duty_ch0;
      ptcm_pkg::CMD_POUT: rd_nxt = pi ? pout_ch1 : pout_ch0;
      ptcm_pkg::CMD_REV: rd_nxt = {8'h00, ptcm_pkg::PROTO_REV};
      ptcm_pkg::CMD_MAKER: rd_nxt = {8'h00, ptcm_pkg::MAKER_CODE};
      ptcm_pkg::CMD_PART: rd_nxt = {8'h00, ptcm_pkg::PART_CODE};
      ptcm_pkg::CMD_SERIAL: rd_nxt = {8'h00, serial_byte};
      ptcm_pkg::CMD_VCEIL:
        rd_nxt = pi ? ptcm_pkg::VCEIL_CH1 : ptcm_pkg::VCEIL_CH0;
      ptcm_pkg::CMD_OEM0: rd_nxt = oem0_r;
      ptcm_pkg::CMD_TOOL: rd_nxt = tool_r[pi];
      ptcm_pkg::CMD_OEM2: rd_nxt = oem2_r;
      ptcm_pkg::CMD_UPAGED: rd_nxt = upaged_r[pi];
      ptcm_pkg::CMD_USHARED: rd_nxt = ushared_r;
      ptcm_pkg::CMD_INFO: rd_nxt = ptcm_pkg::INFO_WORD;
      ptcm_pkg::CMD_UNLOCK: rd_nxt = {14'h0000, !idle, unlocked_r};
      ptcm_pkg::CMD_ERASE: rd_nxt = {15'h0000, !idle};
      ptcm_pkg::CMD_STREAM: rd_nxt = nvm_r[ptr_r];
      ptcm_pkg::CMD_CHCFG: rd_nxt = {8'h00, chcfg_r[pi]};
      ptcm_pkg::CMD_GLCFG: rd_nxt = {8'h00, glcfg_r};
      ptcm_pkg::CMD_PROP: rd_nxt = prop_r[pi];
      ptcm_pkg::CMD_MOD: rd_nxt = {8'h00, mod_r[pi]};
      ptcm_pkg::CMD_PINACT: rd_nxt = {8'h00, pinact_r[pi]};
      ptcm_pkg::CMD_OTACT: rd_nxt = {8'h00, ptcm_pkg::OT_ACTION};
      ptcm_pkg::CMD_PEAK: rd_nxt = pi ? peak1 : peak0;
      ptcm_pkg::CMD_CHADDR: rd_nxt = {8'h00, chaddr_r[pi]};
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_rdata <= 16'h0000;
    end else if (cmd_rd && !cmd_refused) begin
      cmd_rdata <= rd_nxt;
    end
  end

  // ----------------------------------------
  // Fault pins: synchronised input, masked propagation
  // ----------------------------------------
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_prev_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_r <= 2'b11;
      pin_s2_r <= 2'b11;
      pin_prev_r <= 2'b11;
    end else begin
      pin_s1_r <= fault_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  // Falling edge of the pin while not driving it ourselves
  assign pin_action_trig = pin_prev_r & ~pin_s2_r &
                           fault_pin_oe_n;
  assign pin_action_ch0 = pinact_r[0];
  assign pin_action_ch1 = pinact_r[1];
  assign ot_action = ptcm_pkg::OT_ACTION;

  // Open drain: pin driven low when any selected fault is present
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_pin_oe_n <= 2'b11;
    end else begin
      fault_pin_oe_n[0] <= ~|(prop_r[0] & fault_src_ch0);
      fault_pin_oe_n[1] <= ~|(prop_r[1] & fault_src_ch1);
    end
  end
  assign fault_pin_out = 2'b00;

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  // Only the diode reading reaches processing; die reading stays isolated
  assign sense_temp_ch0 = temp_ext_ch0;
  assign sense_temp_ch1 = temp_ext_ch1;
  assign chcfg_ch0 = chcfg_r[0];
  assign chcfg_ch1 = chcfg_r[1];
  assign glcfg = glcfg_r;
  assign mod_ch0 = mod_r[0];
  assign mod_ch1 = mod_r[1];
  assign chaddr_ch0 = chaddr_r[0][6:0];
  assign chaddr_ch1 = chaddr_r[1][6:0];
  assign chaddr_en = {~chaddr_r[1][7], ~chaddr_r[0][7]};
endmodule

// [bench/ptcm_map_checker.sv]
// Purpose: port-level assertions for the command map
// Assumes: one clock, synchronous active-high reset
// Notes: codes written as literals to keep properties short
`timescale 1ns/100ps
module ptcm_map_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic page,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic wr_unpublished_ro,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_refused,
  input wire logic comm_fault_r,
  input wire logic [15:0] temp_ext_ch0,
  input wire logic nvm_busy,
  input wire logic [15:0] sense_temp_ch0,
  input wire logic [7:0] ot_action,
  input wire logic [7:0] chcfg_ch0,
  input wire logic [7:0] glcfg
);
  // --------------------------------
  // Assertions
  // --------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ot_fixed: assert property (ot_action == 8'hc0)
    else $error("overheat action not fixed");
  a_sense_ext: assert property (sense_temp_ch0 == temp_ext_ch0)
    else $error("sense temperature not external reading");
  a_glcfg_reset: assert property (
    $past(sys_rst) |-> glcfg == 8'h09)
    else $error("global config reset value wrong");
  a_busy_refuse: assert property (
    nvm_busy && (cmd_wr || cmd_rd) |-> cmd_refused && !cmd_ack)
    else $error("access accepted while busy");
  a_erase_busy: assert property (
    cmd_wr && cmd_ack && cmd_code == 8'hbe && cmd_wdata[7:0] == 8'h2c
    |=> nvm_busy [*8])
    else $error("erase did not hold busy");
  a_chcfg_write: assert property (
    cmd_wr && cmd_ack && !page && cmd_code == 8'hd0
    |=> chcfg_ch0 == $past(cmd_wdata[7:0]))
    else $error("channel config write lost");
  a_fault_set: assert property (
    wr_unpublished_ro |=> comm_fault_r)
    else $error("fault status not raised");
  a_rev_read: assert property (
    cmd_rd && cmd_ack && cmd_code == 8'h98 |=> cmd_rdata == 16'h0022)
    else $error("revision read wrong");
endmodule

bind ptcm_map ptcm_map_checker ptcm_map_checker_i (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .page(page), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
  .wr_unpublished_ro(wr_unpublished_ro), .cmd_rdata(cmd_rdata),
  .cmd_ack(cmd_ack), .cmd_refused(cmd_refused),
  .comm_fault_r(comm_fault_r), .temp_ext_ch0(temp_ext_ch0),
  .nvm_busy(nvm_busy), .sense_temp_ch0(sense_temp_ch0),
  .ot_action(ot_action), .chcfg_ch0(chcfg_ch0), .glcfg(glcfg));

// [bench/ptcm_host.sv]
// Purpose: host side issuing command reads and writes
// Assumes: strobes launched and released on falling edges
// Notes: write data parked inverted so stale values never match
`timescale 1ns/100ps
module ptcm_host (
  input wire logic sys_clk,
  input wire logic cmd_ack,
  input wire logic cmd_refused,
  input wire logic [15:0] cmd_rdata,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, output logic ok, output logic [15:0] q);
    @(negedge sys_clk);
    cmd_wr = w;
    cmd_rd = !w;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge sys_clk);
    ok = cmd_ack && !cmd_refused;
    @(negedge sys_clk);
    q = cmd_rdata;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = ~d;
  endtask
endmodule

// [bench/ptcm_map_tb_top.sv]
// Purpose: directed checks of the command map
// Assumes: inputs driven on falling edges
// Notes: pulse inputs grouped in one vector to share a helper
`timescale 1ns/100ps
module ptcm_map_tb_top;
  logic sys_clk = 1'b0, sys_rst = 1'b1, page = 1'b0, ok;
  logic cmd_wr, cmd_rd, cmd_ack, cmd_refused, comm_fault_r, nvm_busy;
  logic [7:0] cmd_code, serial_byte = 8'h6e;
  logic [15:0] cmd_wdata, cmd_rdata, q, sense_temp_ch0;
  logic [15:0] vout_ch0 = 16'h0a01, vout_ch1 = 16'h0a02;
  logic [15:0] iout_ch0 = 16'h0b01, iout_ch1 = 16'h0b02;
  logic [15:0] temp_ext_ch0 = 16'h0c01, temp_ext_ch1 = 16'h0c02;
  logic [15:0] duty_ch0 = 16'h0d01, duty_ch1 = 16'h0d02;
  logic [15:0] pout_ch0 = 16'h0e01, pout_ch1 = 16'h0e02;
  logic [15:0] temp_die = 16'h0f00, fault_src_ch0 = 16'h0000;
  logic [1:0] fault_pin_in = 2'b11, pin_action_trig, chaddr_en;
  logic [1:0] fault_pin_oe_n;
  logic [6:0] chaddr_ch0;
  logic [5:0] pl = 6'h00;
  logic wr_unpublished_ro, comm_fault_clear, iout_valid;
  logic peak_clear_request, store_all, restore_all;
  int mismatches = 0, n_checks = 0, cnt = 0;

  assign {wr_unpublished_ro, comm_fault_clear, iout_valid,
    peak_clear_request, store_all, restore_all} = pl;
  always #2.5 sys_clk = ~sys_clk;

  ptcm_map ptcm_map_i (.sys_clk, .sys_rst, .page, .cmd_wr, .cmd_rd,
    .cmd_code, .cmd_wdata, .wr_unpublished_ro, .cmd_rdata, .cmd_ack,
    .cmd_refused, .comm_fault_r, .comm_fault_clear, .vout_ch0, .vout_ch1,
    .iout_ch0, .iout_ch1, .iout_valid, .temp_ext_ch0, .temp_ext_ch1,
    .temp_die, .duty_ch0, .duty_ch1, .pout_ch0, .pout_ch1, .serial_byte,
    .peak_clear_request, .store_all, .restore_all, .nvm_busy,
    .sense_temp_ch0, .sense_temp_ch1(), .fault_pin_in, .fault_src_ch0,
    .fault_src_ch1(fault_src_ch0), .fault_pin_out(), .fault_pin_oe_n,
    .pin_action_ch0(), .pin_action_ch1(), .pin_action_trig, .ot_action(),
    .chcfg_ch0(), .chcfg_ch1(), .glcfg(), .mod_ch0(), .mod_ch1(),
    .chaddr_ch0, .chaddr_ch1(), .chaddr_en);
  ptcm_host ptcm_host_i (.sys_clk, .cmd_ack, .cmd_refused, .cmd_rdata,
    .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata);

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    ptcm_host_i.xfer(1'b1, c, d, ok, q);
    chk($sformatf("accept %h", c), {15'h0, e}, {15'h0, ok});
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    ptcm_host_i.xfer(1'b0, c, 16'h0000, ok, q);
    chk($sformatf("read %h", c), e, q);
  endtask
  task automatic pulse(input int b);
    @(negedge sys_clk);
    pl[b] = 1'b1;
    @(negedge sys_clk);
    pl[b] = 1'b0;
  endtask
  task automatic idle_wait();
    int i;
    for (i = 0; i < 200 && nvm_busy !== 1'b0; i++) @(negedge sys_clk);
    if (nvm_busy !== 1'b0) begin
      mismatches++;
      summarize();
    end
  endtask

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      page = (p == 1);
      rd(8'hd0, 16'h001f);
      rd(8'hd2, 16'h2993);
      rd(8'hd4, 16'h00c2);
      rd(8'hd5, 16'h00c0);
      rd(8'hd8, 16'h0080);
      rd(8'hb3, 16'h0000);
      rd(8'h8b, p ? vout_ch1 : vout_ch0);
      rd(8'h8c, p ? iout_ch1 : iout_ch0);
      rd(8'h8d, p ? temp_ext_ch1 : temp_ext_ch0);
      rd(8'h94, p ? duty_ch1 : duty_ch0);
      rd(8'h96, p ? pout_ch1 : pout_ch0);
      rd(8'ha5, p ? 16'h5800 : 16'h4189);
    end
    rd(8'hd1, 16'h0009);
    rd(8'h8e, temp_die);
    rd(8'h98, 16'h0022);
    rd(8'h9e, {8'h00, serial_byte});
    rd(8'hb4, 16'h0000);
    chk("chaddr_en", 16'h0000, {14'h0, chaddr_en});
    page = 1'b0;
    wr(8'hd0, 16'h0055, 1'b1);
    wr(8'hb4, 16'h1234, 1'b1);
    wr(8'hd8, 16'h0045, 1'b1);
    chk("chaddr", 16'h0045, {9'h0, chaddr_ch0});
    chk("chaddr_en", 16'h0001, {14'h0, chaddr_en});
    page = 1'b1;
    rd(8'hd0, 16'h001f);
    rd(8'hb4, 16'h1234);
    wr(8'hd6, 16'h0012, 1'b1);
    rd(8'hd6, 16'h00c0);
    wr(8'h8b, 16'h1234, 1'b1);
    rd(8'h8b, vout_ch1);
    page = 1'b0;
    rd(8'hd0, 16'h0055);
    pulse(5);
    chk("fault", 16'h0001, {15'h0, comm_fault_r});
    pulse(4);
    chk("fault", 16'h0000, {15'h0, comm_fault_r});
    iout_ch0 = 16'h0300;
    pulse(3);
    iout_ch0 = 16'h0100;
    pulse(3);
    rd(8'hd7, 16'h0300);
    pulse(2);
    rd(8'hd7, 16'h0000);
    wr(8'hbe, 16'h002c, 1'b0);
    wr(8'hbf, 16'h1111, 1'b0);
    wr(8'hbd, 16'h002b, 1'b1);
    wr(8'hbe, 16'h002c, 1'b1);
    wr(8'hd1, 16'h0000, 1'b0);
    idle_wait();
    rd(8'hbf, 16'hffff);
    wr(8'hbd, 16'h002b, 1'b1);
    wr(8'hbf, 16'ha5a5, 1'b1);
    wr(8'hbf, 16'h5a5a, 1'b1);
    wr(8'hbd, 16'h002b, 1'b1);
    rd(8'hbf, 16'ha5a5);
    rd(8'hbf, 16'h5a5a);
    wr(8'hd1, 16'h0044, 1'b1);
    pulse(1);
    idle_wait();
    wr(8'hd1, 16'h0033, 1'b1);
    pulse(0);
    idle_wait();
    rd(8'hd1, 16'h0044);
    fault_src_ch0 = 16'h0004;
    repeat (2) @(negedge sys_clk);
    chk("oe_n", 16'h0003, {14'h0, fault_pin_oe_n});
    fault_src_ch0 = 16'h0001;
    repeat (2) @(negedge sys_clk);
    chk("oe_n", 16'h0000, {14'h0, fault_pin_oe_n});
    fault_src_ch0 = 16'h0000;
    repeat (2) @(negedge sys_clk);
    chk("oe_n", 16'h0003, {14'h0, fault_pin_oe_n});
    fault_pin_in = 2'b10;
    repeat (8) begin
      @(negedge sys_clk);
      cnt += pin_action_trig[0];
    end
    chk("pin trig", 16'h0001, cnt[15:0]);
    summarize();
  end
endmodule
